/* File: dv/four_port_parallel_io_properties.sv */
// Checker: port-level properties of the parallel I/O block.
// Assumes bind to the block's top module; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module four_port_parallel_io_properties
	import parallel_io_pkg::*;
(
	// Clock, reset and bus
	input wire logic       core_clk, sys_rst, bus_write, bus_read, compare_level,
	input wire logic [2:0] bus_addr,
	input wire logic [7:0] bus_wdata, bus_rdata,
	// Pins and sub-system sharing
	input wire logic [7:0] port_a_out, port_a_oe, port_b_out, port_b_oe, port_b_in,
	input wire logic [7:0] shared_port_pins_in, shared_port_pins_out, shared_port_pins_oe,
	input wire logic [7:0] subsys_drive_en, subsys_drive_val
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// Pins held still long enough to pass the synchroniser
	sequence quiet(logic [7:0] p); $stable(p)[*3]; endsequence
	chk_dir_reset: assert property ($fell(sys_rst) |-> {port_a_oe, port_b_oe, shared_port_pins_oe} == 24'h000040)
		else $error("direction not cleared");
	chk_dir_write: assert property (bus_write && bus_addr == PORT_A_DIR |=> port_a_oe == $past(bus_wdata))
		else $error("direction write lost");
	chk_latch_write: assert property (bus_write && bus_addr == PORT_B_DATA |=> port_b_out == $past(bus_wdata))
		else $error("latch write lost");
	chk_compare_line: assert property (shared_port_pins_oe[6] && shared_port_pins_out[6] == compare_level)
		else $error("compare line wrong");
	chk_subsys_drive: assert property (((shared_port_pins_out ^ subsys_drive_val) & subsys_drive_en & 8'hBF) == 8'h00)
		else $error("takeover value wrong");
	chk_read_latch: assert property (bus_read && bus_addr == PORT_A_DATA |=>
		((bus_rdata ^ $past(port_a_out)) & $past(port_a_oe)) == 8'h00)
		else $error("output bits not from latch");
	chk_pin_sync: assert property (quiet(port_b_in) ##0 (bus_read && bus_addr == PORT_B_DATA && port_b_oe == 8'h00)
		|=> bus_rdata == $past(port_b_in))
		else $error("input pins misread");
	chk_port_d_pins: assert property (quiet(shared_port_pins_in) ##0 (bus_read && bus_addr == PORT_D_DATA)
		|=> bus_rdata == $past(shared_port_pins_in))
		else $error("shared pins misread");
endmodule : four_port_parallel_io_properties
bind four_port_parallel_io four_port_parallel_io_properties i_props(.core_clk, .sys_rst, .bus_write, .bus_read,
	.compare_level, .bus_addr, .bus_wdata, .bus_rdata, .port_a_out, .port_a_oe, .port_b_out, .port_b_oe,
	.port_b_in, .shared_port_pins_in, .shared_port_pins_out, .shared_port_pins_oe, .subsys_drive_en,
	.subsys_drive_val);
`default_nettype wire

/* File: dv/pin_board.sv */
// Board model: resolves one port's pin levels.
// Assumes outside levels come from the bench.
`timescale 1ns/1ps
`default_nettype none
module pin_board (
	// Block drive
	input  wire logic [7:0] pin_out,
	input  wire logic [7:0] pin_oe,
	// Outside source and resolved level
	input  wire logic [7:0] ext_level,
	output wire logic [7:0] level
);
	// Released bits follow the outside source, so a stale latch never shows
	assign level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : pin_board
`default_nettype wire

/* File: dv/test_four_port_parallel_io.sv */
// Bench: register walk, pin sharing and reset cases.
// Assumes board models on all four ports and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module test_four_port_parallel_io
	import parallel_io_pkg::*;
;
	typedef struct packed {logic [2:0] a; logic [7:0] d; logic [7:0] e;} row_t;
	logic       core_clk = 0, sys_rst = 1, bus_write = 0, bus_read = 0, compare_level = 1;
	logic [2:0] bus_addr = 0;
	logic [7:0] bus_wdata = 0, bus_rdata, r, en = 0, val = 0;
	logic [7:0] po[4], oe[4], lvl[4], ext[4] = '{8'h3C, 8'hC3, 8'h97, 8'hA4};
	int         n_fail = 0, checks_done = 0;
	// Write, then read back
	row_t rows[10] = '{'{3'h0, 8'h5A, 8'h3C}, '{3'h4, 8'hF0, 8'hF0}, '{3'h0, 8'h5A, 8'h5C}, '{3'h1, 8'h81, 8'hC3},
		'{3'h5, 8'hFF, 8'hFF}, '{3'h1, 8'h81, 8'h81}, '{3'h2, 8'h00, 8'h97}, '{3'h6, 8'h01, 8'h01},
		'{3'h7, 8'hFF, 8'hBF}, '{3'h3, 8'h00, 8'h40}};
	four_port_parallel_io i_four_port_parallel_io(.core_clk, .sys_rst, .bus_addr, .bus_write, .bus_read,
		.bus_wdata, .bus_rdata, .port_a_in(lvl[0]), .port_a_out(po[0]), .port_a_oe(oe[0]),
		.port_b_in(lvl[1]), .port_b_out(po[1]), .port_b_oe(oe[1]), .port_c_in(lvl[2]), .port_c_out(po[2]),
		.port_c_oe(oe[2]), .shared_port_pins_in(lvl[3]), .shared_port_pins_out(po[3]),
		.shared_port_pins_oe(oe[3]), .subsys_drive_en(en), .subsys_drive_val(val), .compare_level);
	for (genvar i = 0; i < 4; i++)
	begin : g_pin
		pin_board i_pin_board(.pin_out(po[i]), .pin_oe(oe[i]), .ext_level(ext[i]), .level(lvl[i]));
	end
	initial forever #4 core_clk = ~core_clk;
	// One bus access, launched at the falling edge
	task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr = a; bus_wdata = d; bus_write = w; bus_read = !w;
		@(negedge core_clk);
		bus_write = 0; bus_read = 0; r = bus_rdata;
	endtask : acc
	task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	initial
	begin
		repeat (3) @(negedge core_clk);
		sys_rst = 0;
		foreach (rows[i])
		begin
			acc(1, rows[i].a, rows[i].d);
			// Pin levels need two clocks through the synchroniser
			repeat (2) @(negedge core_clk);
			acc(0, rows[i].a, 8'h00);
			chk("row read", r, rows[i].e);
			$display("row %0d done", i);
		end
		chk("c pin", lvl[2], 8'h96);
		en = 8'h01; val = 8'h01;
		repeat (3) @(negedge core_clk);
		chk("d pin", lvl[3], 8'h41);
		acc(0, PORT_D_DATA, 8'h00);
		chk("d read", r, 8'h41);
		$display("sharing done");
		sys_rst = 1;
		@(negedge core_clk);
		sys_rst = 0;
		chk("oe", {oe[0], oe[1], oe[2], oe[3]}, 32'h40);
		chk("b latch", po[1], 8'h81);
		chk("c pin", lvl[2], 8'h97);
		chk("d pin", lvl[3], 8'hE4);
		// Released port B pins must pass the synchroniser first
		repeat (2) @(negedge core_clk);
		acc(0, PORT_B_DATA, 8'h00);
		chk("b read", r, 8'hC3);
		$display("reset done");
		complete_run();
	end
	// Tests need under a hundred cycles; five hundred means a hang
	initial
	begin
		#4000;
		n_fail++;
		complete_run();
	end
endmodule : test_four_port_parallel_io
`default_nettype wire

/* File: verilog/four_port_parallel_io.sv */
// Four byte-wide parallel ports with direction registers and output latches.
// Assumes a synchronous byte bus with one-cycle write and registered read data; pins resolved outside.
// Function
// - Four eight-line ports: thirty-one bidirectional lines, one output-only line.
// - A pin drives when its direction bit is one, else it is input; port D bit 6 always drives.
// - Reset clears every direction register, making all pins inputs except port D bit 6.
// - Reset leaves output data latches untouched; their power-up value is undefined.
// - Software can write and read back every direction register; port D direction bit 6 always reads zero.
// - Data writes always update the latch; the pin drives only when direction is one, except port D bit 6.
// - Data reads of ports A-C return pin level for inputs, latch value for outputs.
// - Data registers of ports A-C at 0-2, their directions at 4-6.
// - Port D pins are shared with timer, serial and pulse-width sub-systems.
// - Shared port D bits still read the pin level while a sub-system runs.
// - Enabled sub-system supplies the pin value on bits 0-5 and 7; direction still gates their drivers.
// - Port D data at 3, direction at 7; bits 0-5 and 7 bidirectional.
// - Port D bit 6 is the compare output; reads give its pin level.
// - Port D data reads always reflect the actual pin level.
// - Zero latch with direction toggling gives open-drain style drive low or float.
// - Port D direction bits are zero at reset; bit 6 always reads zero while its driver stays on.
`timescale 1ns/1ps
`default_nettype none
module four_port_parallel_io
	import parallel_io_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  sys_rst,
	// Internal processor bus
	input  wire logic [ADDR_WIDTH-1:0] bus_addr,
	input  wire logic                  bus_write,
	input  wire logic                  bus_read,
	input  wire logic [WIDTH-1:0]      bus_wdata,
	output var  logic [WIDTH-1:0]      bus_rdata,
	// Port A pins
	input  wire logic [WIDTH-1:0]      port_a_in,
	output var  logic [WIDTH-1:0]      port_a_out,
	output var  logic [WIDTH-1:0]      port_a_oe,
	// Port B pins
	input  wire logic [WIDTH-1:0]      port_b_in,
	output var  logic [WIDTH-1:0]      port_b_out,
	output var  logic [WIDTH-1:0]      port_b_oe,
	// Port C pins
	input  wire logic [WIDTH-1:0]      port_c_in,
	output var  logic [WIDTH-1:0]      port_c_out,
	output var  logic [WIDTH-1:0]      port_c_oe,
	// Port D shared pins
	input  wire logic [WIDTH-1:0]      shared_port_pins_in,
	output var  logic [WIDTH-1:0]      shared_port_pins_out,
	output var  logic [WIDTH-1:0]      shared_port_pins_oe,
	// Sub-system pin sharing: per-bit takeover and drive value
	input  wire logic [WIDTH-1:0]      subsys_drive_en,
	input  wire logic [WIDTH-1:0]      subsys_drive_val,
	// Timer compare level, driven out on the dedicated line
	input  wire logic                  compare_level
);
	typedef struct packed {
		logic [WIDTH-1:0] latch_a;
		logic [WIDTH-1:0] latch_b;
		logic [WIDTH-1:0] latch_c;
		logic [WIDTH-1:0] latch_d;
		logic [WIDTH-1:0] dir_a;
		logic [WIDTH-1:0] dir_b;
		logic [WIDTH-1:0] dir_c;
		logic [WIDTH-1:0] dir_d;
		logic [WIDTH-1:0] rdata;
	} io_state_t;

	io_state_t        state;
	io_state_t        next_state;
	logic [WIDTH-1:0] sync_a;
	logic [WIDTH-1:0] sync_b;
	logic [WIDTH-1:0] sync_c;
	logic [WIDTH-1:0] sync_d;
	logic [WIDTH-1:0] read_mux;
	logic [WIDTH-1:0] d_value;

	generate
		if (WIDTH != PORT_WIDTH)
		begin : g_bad_width
			$error("four_port_parallel_io supports only byte-wide ports");
		end
	endgenerate

	// Pin levels cross into the bus clock before any read sees them
	pin_sync #(.WIDTH(WIDTH)) u_sync_a (.core_clk(core_clk), .async_in(port_a_in), .sync_out(sync_a));
	pin_sync #(.WIDTH(WIDTH)) u_sync_b (.core_clk(core_clk), .async_in(port_b_in), .sync_out(sync_b));
	pin_sync #(.WIDTH(WIDTH)) u_sync_c (.core_clk(core_clk), .async_in(port_c_in), .sync_out(sync_c));
	pin_sync #(.WIDTH(WIDTH)) u_sync_d
	(
		.core_clk (core_clk),
		.async_in (shared_port_pins_in),
		.sync_out (sync_d)
	);

	// Register map, one byte per index:
	// 0-2 data of ports A-C, 3 data of port D,
	// 4-6 direction of ports A-C, 7 direction of port D.
	// Data reads of input bits see the pin two clocks late,
	// so software polling a fast pin sees a delayed level.
	// Port D data always reads the pin, whatever the direction,
	// which lets software watch sub-system outputs on the pins.
	// Read data selection per register index
	always_comb
	begin
		read_mux = '0;
		unique case (bus_addr)
			PORT_A_DATA: read_mux = (state.dir_a & state.latch_a) | (~state.dir_a & sync_a);
			PORT_B_DATA: read_mux = (state.dir_b & state.latch_b) | (~state.dir_b & sync_b);
			PORT_C_DATA: read_mux = (state.dir_c & state.latch_c) | (~state.dir_c & sync_c);
			PORT_D_DATA: read_mux = sync_d;
			PORT_A_DIR:  read_mux = state.dir_a;
			PORT_B_DIR:  read_mux = state.dir_b;
			PORT_C_DIR:  read_mux = state.dir_c;
			PORT_D_DIR:  read_mux = state.dir_d;
		endcase
	end

	// Register writes; data latches are written regardless of direction
	always_comb
	begin
		next_state = state;
		if (bus_read)
		begin
			next_state.rdata = read_mux;
		end
		if (bus_write)
		begin
			unique case (bus_addr)
				PORT_A_DATA: next_state.latch_a = bus_wdata;
				PORT_B_DATA: next_state.latch_b = bus_wdata;
				PORT_C_DATA: next_state.latch_c = bus_wdata;
				PORT_D_DATA: next_state.latch_d = bus_wdata;
				PORT_A_DIR:  next_state.dir_a = bus_wdata;
				PORT_B_DIR:  next_state.dir_b = bus_wdata;
				PORT_C_DIR:  next_state.dir_c = bus_wdata;
				PORT_D_DIR:  next_state.dir_d = bus_wdata & PORT_D_DIR_MASK;
			endcase
		end
	end

	// Reset touches only direction and read data, never the data latches
	always_ff @(posedge core_clk)
	begin
		state <= next_state;
		if (sys_rst)
		begin
			state.dir_a <= DIR_RESET;
			state.dir_b <= DIR_RESET;
			state.dir_c <= DIR_RESET;
			state.dir_d <= DIR_RESET;
			state.rdata <= '0;
		end
	end
	// Latches carry no reset term at all

	// Sub-systems take over the value, direction keeps the driver gate
	always_comb
	begin
		d_value = (subsys_drive_en & subsys_drive_val) | (~subsys_drive_en & state.latch_d);
		d_value[COMPARE_BIT] = compare_level;
	end

	// Pin drivers of ports A-C: value is latch, enable is direction bit
	assign port_a_out = state.latch_a;
	assign port_a_oe  = state.dir_a;
	assign port_b_out = state.latch_b;
	assign port_b_oe  = state.dir_b;
	assign port_c_out = state.latch_c;
	assign port_c_oe  = state.dir_c;
	assign shared_port_pins_out = d_value;
	// Bit 6 always drives; the other seven follow direction
	assign shared_port_pins_oe  = (state.dir_d & PORT_D_DIR_MASK) | ~PORT_D_DIR_MASK;
	assign bus_rdata = state.rdata;
endmodule : four_port_parallel_io
`default_nettype wire

/* File: verilog/parallel_io_pkg.sv */
// Package for the four-port parallel I/O block: register indices, widths, reset values.
// Assumes a byte-wide internal processor bus with a small register address.
package parallel_io_pkg;
	localparam int          PORT_WIDTH      = 8;
	localparam int          PORT_COUNT      = 4;
	localparam int          ADDR_WIDTH      = 3;
	// Register indices on the internal bus
	localparam logic [2:0]  PORT_A_DATA     = 3'h0;
	localparam logic [2:0]  PORT_B_DATA     = 3'h1;
	localparam logic [2:0]  PORT_C_DATA     = 3'h2;
	localparam logic [2:0]  PORT_D_DATA     = 3'h3;
	localparam logic [2:0]  PORT_A_DIR      = 3'h4;
	localparam logic [2:0]  PORT_B_DIR      = 3'h5;
	localparam logic [2:0]  PORT_C_DIR      = 3'h6;
	localparam logic [2:0]  PORT_D_DIR      = 3'h7;
	// Bank select bit: upper half holds direction registers
	localparam int          DIR_SEL_BIT     = 2;
	// Reset and field constants
	localparam logic [7:0]  DIR_RESET       = 8'h00;
	localparam int          COMPARE_BIT     = 6;
	localparam logic [7:0]  PORT_D_DIR_MASK = 8'hBF;
endpackage : parallel_io_pkg

/* File: verilog/pin_sync.sv */
// Two-stage synchroniser for a bus of pin levels.
// Assumes pins are free-running asynchronous levels; output lags by two clocks.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int WIDTH = 8
) (
	// Clock
	input  wire logic             core_clk,
	// Pin levels in, synchronised levels out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_t;

	sync_state_t state;
	sync_state_t next_state;

	generate
		if (WIDTH < 1)
		begin : g_bad
			$error("pin_sync needs WIDTH of at least one");
		end
	endgenerate

	// Second stage alone reads the first
	always_comb
	begin
		next_state.first  = async_in;
		next_state.second = state.first;
	end

	// No reset: a synchroniser carries no control state
	always_ff @(posedge core_clk)
	begin
		state <= next_state;
	end

	assign sync_out = state.second;
endmodule : pin_sync
`default_nettype wire
